// ### verilog/cwh_defs.svh
// Register map, field positions and reset values of the standby controller
`ifndef CWH_DEFS_SVH
`define CWH_DEFS_SVH

// ==========================================================
// Bus geometry
`define CWH_ADDR_W 4
`define CWH_DATA_W 32
`define CWH_IDX_HI 3
`define CWH_IDX_LO 2
`define CWH_BE_LANE0 0

// ==========================================================
// Register indices (byte address is four times the index)
`define CWH_IDX_CTRL3 2'h0
`define CWH_IDX_DIV 2'h1
`define CWH_IDX_CFG 2'h2
`define CWH_IDX_STAT 2'h3

// ==========================================================
// system_clock_control_3 fields
`define CWH_B_WREQ 0
`define CWH_B_BYP 5
`define CWH_B_WSEL_LO 6
`define CWH_B_WSEL_HI 7

// Divide and source register fields
`define CWH_DIV_LSB 0
`define CWH_DIV_MSB 2
`define CWH_SRC_LSB 4
`define CWH_SRC_MSB 5

// Configuration register: 1 selects the halt variant
`define CWH_B_VARIANT 0

// Status register fields
`define CWH_ST_STATE_LSB 0
`define CWH_ST_STATE_MSB 2
`define CWH_ST_SRC_LSB 3
`define CWH_ST_SRC_MSB 4
`define CWH_ST_UNDIV 5
`define CWH_ST_HALT 6

// ==========================================================
// Codes and reset values
`define CWH_WSEL_KEEP 2'h0
`define CWH_WSEL_MAIN 2'h3
`define CWH_SRC_ONCHIP 2'h0
`define CWH_SRC_MAIN 2'h1
`define CWH_RST_DIV 3'h0
`define CWH_RST_SRC 2'h0
`define CWH_RST_WSEL 2'h0
`define CWH_RST_BYP 1'h0
`define CWH_RST_VARIANT 1'h0
`define CWH_DIV_NONE 3'h0
`define CWH_OSC_ALL 2'h3

`endif

// ### verilog/cwh_pkg.sv
// Types shared by the standby controller files
package cwh_pkg;

   // ==========================================================
   // Controller states, one-hot
   typedef enum logic [2:0] {
      CWH_ST_RUN = 3'b001,
      CWH_ST_STOP = 3'b010,
      CWH_ST_WAKE = 3'b100
   } cwh_state_t;

   // ==========================================================
   // CPU core to controller
   typedef struct packed {
      logic wait_instr;
      logic halt_instr;
      logic global_interrupt_enable;
   } cwh_cpu_req_t;

   // Controller to CPU core
   typedef struct packed {
      logic clk_en;
      logic stopped;
      logic resume;
      logic take_vector;
   } cwh_cpu_rsp_t;

endpackage : cwh_pkg

// ### verilog/cwh_clk_div.sv
// Power-of-two CPU clock enable divider
`timescale 1ns/100ps

module cwh_clk_div #(
   parameter int CODE_W = 3
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Control
   input wire logic run,
   input wire logic [CODE_W-1:0] code,
   // Enable pulse
   output logic tick
);

   localparam int CNT_W = (2 ** CODE_W) - 1;

   if (CODE_W < 1 || CODE_W > 4)
   begin : g_bad_code
      $error("cwh_clk_div: CODE_W must be 1 to 4");
   end

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] lim;
   logic tick_q;

   // Divide by two to the power of code; code 0 ticks every cycle
   assign lim = (CNT_W'(1) << code) - CNT_W'(1);

   // ==========================================================
   // Counter restarts while stopped so the first tick after a
   // wake-up comes one full period later, never a runt
   always_ff @(posedge clk)
   begin
      if (reset || !run || cnt_q >= lim)
         cnt_q <= '0;
      else
         cnt_q <= cnt_q + CNT_W'(1);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         tick_q <= 1'h0;
      else
         tick_q <= run && (cnt_q >= lim);
   end

   assign tick = tick_q;

endmodule : cwh_clk_div

// ### verilog/cwh_standby_ctrl.sv
// Standby controller: CPU clock gating in wait or halt state
`timescale 1ns/100ps
`include "cwh_defs.svh"

// What this block does
// - Wait variant: wait instruction enters wait; interrupts enabled first.
// - Wait variant: writing 1 to wait_request_bit enters wait.
// - Any peripheral interrupt request or reset ends wait or halt.
// - In wait, output pins keep their levels from just before entry.
// - Wait exit source: select 00b keeps prior source, 11b main osc.
// - Wait exit: bypass 1 runs undivided, bypass 0 uses divide bits.
// - Halt variant: only halt instruction enters halt; interrupts on first.
// - In halt, pins keep the levels from just before the instruction.
// - Halt exit resumes with the clock source used before entry.
// - Halt exit keeps the division ratio used before entry.
// - Halt stops only the CPU clock; oscillators and peripherals run.
module cwh_standby_ctrl #(
   parameter int PIN_W = 8,
   parameter int IRQ_W = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Avalon-MM register slave
   input wire logic [`CWH_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [`CWH_DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [`CWH_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // CPU core
   input wire cwh_pkg::cwh_cpu_req_t cpu_req,
   output cwh_pkg::cwh_cpu_rsp_t cpu_rsp,
   output logic [1:0] cpu_clk_src,
   // Peripheral interrupt requests
   input wire logic [IRQ_W-1:0] irq_req,
   // Output pins
   input wire logic [PIN_W-1:0] pin_in,
   output logic [PIN_W-1:0] pin_out,
   // Oscillators and peripheral clock
   output logic [1:0] osc_run,
   output logic periph_clk_en
);

   if (PIN_W < 1 || IRQ_W < 1)
   begin : g_bad_width
      $error("cwh_standby_ctrl: PIN_W and IRQ_W must be at least 1");
   end

   // ==========================================================
   // Declarations
   cwh_pkg::cwh_state_t state_q;
   cwh_pkg::cwh_state_t state_d;
   logic waitrequest_q;
   logic [`CWH_DATA_W-1:0] readdata_q;
   logic [`CWH_DATA_W-1:0] rdata_d;
   logic acc;
   logic lane0;
   logic wr_ctrl3;
   logic wr_div;
   logic wr_cfg;
   logic byp_q;
   logic [1:0] wsel_q;
   logic [2:0] div_q;
   logic [1:0] src_q;
   logic undiv_q;
   logic variant_q;
   logic kind_q;
   logic wait_go;
   logic halt_go;
   logic wake;
   logic run;
   logic tick;
   logic [2:0] div_code;
   logic stopped_q;
   logic resume_q;
   logic vec_q;
   logic [PIN_W-1:0] pin_q;
   logic [1:0] osc_q;
   logic periph_q;

   // Register index match, used for every write decode
   function automatic logic hit(
      input logic [`CWH_ADDR_W-1:0] a,
      input logic [1:0] idx
   );
      hit = (a[`CWH_IDX_HI:`CWH_IDX_LO] == idx);
   endfunction : hit

   // ==========================================================
   // Avalon-MM slave: one wait cycle, then the request is taken
   assign acc = !waitrequest_q && (avs_read || avs_write);
   assign lane0 = avs_byteenable[`CWH_BE_LANE0];
   assign wr_ctrl3 = acc && avs_write && lane0
      && hit(avs_address, `CWH_IDX_CTRL3);
   assign wr_div = acc && avs_write && lane0
      && hit(avs_address, `CWH_IDX_DIV);
   assign wr_cfg = acc && avs_write && lane0
      && hit(avs_address, `CWH_IDX_CFG);

   always_ff @(posedge clk)
   begin
      if (reset)
         waitrequest_q <= 1'h1;
      else if (!waitrequest_q)
         waitrequest_q <= 1'h1;
      else
         waitrequest_q <= !(avs_read || avs_write);
   end

   // Unmapped bits and reserved fields read as zero
   always_comb
   begin
      rdata_d = '0;
      unique case (avs_address[`CWH_IDX_HI:`CWH_IDX_LO])
         `CWH_IDX_CTRL3:
         begin
            rdata_d[`CWH_B_WREQ] = stopped_q && !kind_q;
            rdata_d[`CWH_B_BYP] = byp_q;
            rdata_d[`CWH_B_WSEL_HI:`CWH_B_WSEL_LO] = wsel_q;
         end
         `CWH_IDX_DIV:
         begin
            rdata_d[`CWH_DIV_MSB:`CWH_DIV_LSB] = div_q;
            rdata_d[`CWH_SRC_MSB:`CWH_SRC_LSB] = src_q;
         end
         `CWH_IDX_CFG:
            rdata_d[`CWH_B_VARIANT] = variant_q;
         `CWH_IDX_STAT:
         begin
            rdata_d[`CWH_ST_STATE_MSB:`CWH_ST_STATE_LSB] = state_q;
            rdata_d[`CWH_ST_SRC_MSB:`CWH_ST_SRC_LSB] = src_q;
            rdata_d[`CWH_ST_UNDIV] = undiv_q;
            rdata_d[`CWH_ST_HALT] = kind_q;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         readdata_q <= '0;
      else if (waitrequest_q && avs_read)
         readdata_q <= rdata_d;
   end

   // ==========================================================
   // Wake-up settings and variant select
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         byp_q <= `CWH_RST_BYP;
         wsel_q <= `CWH_RST_WSEL;
      end
      else if (wr_ctrl3)
      begin
         byp_q <= avs_writedata[`CWH_B_BYP];
         wsel_q <= avs_writedata[`CWH_B_WSEL_HI:`CWH_B_WSEL_LO];
      end
   end

   // Variant changes only while running, never mid-standby
   always_ff @(posedge clk)
   begin
      if (reset)
         variant_q <= `CWH_RST_VARIANT;
      else if (wr_cfg && state_q == cwh_pkg::CWH_ST_RUN)
         variant_q <= avs_writedata[`CWH_B_VARIANT];
   end

   // ==========================================================
   // Entry and exit conditions
   assign wait_go = state_q == cwh_pkg::CWH_ST_RUN && !variant_q
      && (cpu_req.wait_instr
      || (wr_ctrl3 && avs_writedata[`CWH_B_WREQ]));
   assign halt_go = state_q == cwh_pkg::CWH_ST_RUN && variant_q
      && cpu_req.halt_instr;
   // Mask gating sits in the interrupt controller upstream
   assign wake = state_q == cwh_pkg::CWH_ST_STOP && |irq_req;

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         cwh_pkg::CWH_ST_RUN:
            if (wait_go || halt_go)
               state_d = cwh_pkg::CWH_ST_STOP;
         cwh_pkg::CWH_ST_STOP:
            if (wake)
               state_d = cwh_pkg::CWH_ST_WAKE;
         cwh_pkg::CWH_ST_WAKE:
            state_d = cwh_pkg::CWH_ST_RUN;
         default:
            state_d = cwh_pkg::CWH_ST_RUN;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         state_q <= cwh_pkg::CWH_ST_RUN;
      else
         state_q <= state_d;
   end

   // Remembers which standby was entered, since exit differs
   always_ff @(posedge clk)
   begin
      if (reset)
         kind_q <= 1'h0;
      else if (halt_go)
         kind_q <= 1'h1;
      else if (wait_go)
         kind_q <= 1'h0;
   end

   // ==========================================================
   // CPU clock source and division ratio
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         src_q <= `CWH_RST_SRC;
         div_q <= `CWH_RST_DIV;
         undiv_q <= 1'h0;
      end
      else if (wake && !kind_q)
      begin
         if (wsel_q == `CWH_WSEL_MAIN)
            src_q <= `CWH_SRC_MAIN;
         undiv_q <= byp_q;
      end
      else if (wr_div && state_q == cwh_pkg::CWH_ST_RUN)
      begin
         div_q <= avs_writedata[`CWH_DIV_MSB:`CWH_DIV_LSB];
         src_q <= avs_writedata[`CWH_SRC_MSB:`CWH_SRC_LSB];
         undiv_q <= 1'h0;
      end
      // Halt exit touches neither source nor ratio
   end

   assign div_code = undiv_q ? `CWH_DIV_NONE : div_q;
   // Gate on the next state so no enable leaks into standby
   assign run = state_d == cwh_pkg::CWH_ST_RUN;

   cwh_clk_div #(
      .CODE_W(3)
   ) u_div (
      .clk(clk),
      .reset(reset),
      .run(run),
      .code(div_code),
      .tick(tick)
   );

   // ==========================================================
   // Resume indication to the CPU core
   always_ff @(posedge clk)
   begin
      if (reset)
         stopped_q <= 1'h0;
      else
         stopped_q <= !run;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         resume_q <= 1'h0;
      else
         resume_q <= wake;
   end

   // Interrupts disabled means continue after the entry instruction
   always_ff @(posedge clk)
   begin
      if (reset)
         vec_q <= 1'h0;
      else if (wake)
         vec_q <= cpu_req.global_interrupt_enable;
   end

   // ==========================================================
   // Pin hold: capture only while running
   always_ff @(posedge clk)
   begin
      if (reset)
         pin_q <= '0;
      else if (state_q == cwh_pkg::CWH_ST_RUN)
         pin_q <= pin_in;
   end

   // Oscillators and peripheral clock never stop in this block
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         osc_q <= `CWH_OSC_ALL;
         periph_q <= 1'h1;
      end
      else
      begin
         osc_q <= `CWH_OSC_ALL;
         periph_q <= 1'h1;
      end
   end

   // ==========================================================
   // Outputs
   assign avs_waitrequest = waitrequest_q;
   assign avs_readdata = readdata_q;
   assign cpu_rsp = cwh_pkg::cwh_cpu_rsp_t'{
      clk_en: tick,
      stopped: stopped_q,
      resume: resume_q,
      take_vector: vec_q
   };
   assign cpu_clk_src = src_q;
   assign pin_out = pin_q;
   assign osc_run = osc_q;
   assign periph_clk_en = periph_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_wake_steps;
      state_q == cwh_pkg::CWH_ST_WAKE ##1 state_q == cwh_pkg::CWH_ST_RUN;
   endsequence

   sequence s_stop_exit;
      state_q == cwh_pkg::CWH_ST_STOP && |irq_req;
   endsequence

   a_wait_instr_entry: assert property (
      state_q == cwh_pkg::CWH_ST_RUN && !variant_q && cpu_req.wait_instr
      |=> state_q == cwh_pkg::CWH_ST_STOP && !kind_q && cpu_rsp.stopped)
      else $error("wait instruction did not enter wait");

   a_wait_bit_entry: assert property (
      wr_ctrl3 && avs_writedata[`CWH_B_WREQ] && !variant_q
      && state_q == cwh_pkg::CWH_ST_RUN
      |=> state_q == cwh_pkg::CWH_ST_STOP)
      else $error("wait request bit did not enter wait");

   a_halt_only_instr: assert property (
      state_q == cwh_pkg::CWH_ST_RUN && variant_q && !cpu_req.halt_instr
      |=> state_q == cwh_pkg::CWH_ST_RUN && !cpu_rsp.stopped)
      else $error("halt variant stopped without halt instruction");

   a_halt_entry: assert property (
      state_q == cwh_pkg::CWH_ST_RUN && variant_q
      |=> (state_q == cwh_pkg::CWH_ST_STOP) == $past(cpu_req.halt_instr))
      else $error("halt entered without instruction or missed");

   a_irq_exit: assert property (
      s_stop_exit |=> s_wake_steps)
      else $error("interrupt request did not end standby");

   a_stop_holds: assert property (
      state_q == cwh_pkg::CWH_ST_STOP && !(|irq_req)
      |=> state_q == cwh_pkg::CWH_ST_STOP)
      else $error("standby left without request");

   a_pins_held: assert property (
      state_q != cwh_pkg::CWH_ST_RUN |=> $stable(pin_out))
      else $error("pin level changed in standby");

   a_wake_src_main: assert property (
      s_stop_exit ##0 !kind_q && wsel_q == `CWH_WSEL_MAIN
      |=> cpu_clk_src == `CWH_SRC_MAIN)
      else $error("wake did not switch to main oscillator");

   a_wake_src_keep: assert property (
      s_stop_exit ##0 !kind_q && wsel_q == `CWH_WSEL_KEEP
      |=> $stable(cpu_clk_src))
      else $error("wake changed source with keep select");

   a_wake_ratio: assert property (
      s_stop_exit ##0 !kind_q
      |=> undiv_q == $past(byp_q) && $stable(div_q))
      else $error("wake ratio not set by bypass bit");

   a_halt_keeps_clk: assert property (
      s_stop_exit ##0 kind_q
      |=> $stable(src_q) && $stable(div_q) && $stable(undiv_q))
      else $error("halt exit changed clock source or ratio");

   a_cpu_gated: assert property (
      state_q != cwh_pkg::CWH_ST_RUN
      |-> !cpu_rsp.clk_en && osc_run == `CWH_OSC_ALL && periph_clk_en)
      else $error("CPU clock ran or oscillator stopped in standby");

   a_resume_vector: assert property (
      s_stop_exit |=> cpu_rsp.resume
      && cpu_rsp.take_vector == $past(cpu_req.global_interrupt_enable))
      else $error("resume vectoring does not follow interrupt enable");

endmodule : cwh_standby_ctrl

// ### dv/cwh_cpu_model.sv
// CPU core and interrupt source model facing the standby controller
`timescale 1ns/100ps

module cwh_cpu_model #(
   parameter int IRQ_W = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Commands from the bench
   input wire logic cmd_wait,
   input wire logic cmd_halt,
   input wire logic cmd_ie,
   input wire logic [IRQ_W-1:0] cmd_irq,
   // Controller side
   input wire cwh_pkg::cwh_cpu_rsp_t cpu_rsp,
   output cwh_pkg::cwh_cpu_req_t cpu_req,
   output logic [IRQ_W-1:0] irq_req
);
   // ==========
   // Core: interrupt enable is settled cycles before an entry command
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cpu_req <= '0;
      end
      else
      begin
         cpu_req.global_interrupt_enable <= cmd_ie;
         cpu_req.wait_instr <= cmd_wait;
         cpu_req.halt_instr <= cmd_halt;
      end
   end

   // ==========
   // Sources: only unmasked requests arrive, held until the core resumes
   always_ff @(posedge clk)
   begin
      if (reset || cpu_rsp.resume)
      begin
         irq_req <= '0;
      end
      else
      begin
         irq_req <= irq_req | cmd_irq;
      end
   end
endmodule : cwh_cpu_model

// ### dv/cwh_standby_ctrl_tb.sv
// Self-checking bench for the standby controller
`timescale 1ns/100ps

module cwh_standby_ctrl_tb;
   typedef struct {
      logic halt_v;
      logic [1:0] how;
      logic ie;
      logic [1:0] wsel;
      logic byp;
      logic [2:0] code;
      logic [1:0] src;
      logic [1:0] x_src;
      logic x_und;
      int x_pul;
   } cwh_row_t;

   // ==========
   // Entry: 0 wait instruction, 1 wait request bit, 2 halt instruction
   cwh_row_t rows [6] = '{
      '{1'h0, 2'h0, 1'h1, 2'h0, 1'h0, 3'h1, 2'h0, 2'h0, 1'h0, 8},
      '{1'h0, 2'h1, 1'h0, 2'h3, 1'h1, 3'h2, 2'h0, 2'h1, 1'h1, 16},
      '{1'h0, 2'h0, 1'h1, 2'h1, 1'h0, 3'h0, 2'h1, 2'h1, 1'h0, 16},
      '{1'h0, 2'h1, 1'h0, 2'h2, 1'h0, 3'h3, 2'h1, 2'h1, 1'h0, 2},
      '{1'h1, 2'h2, 1'h1, 2'h3, 1'h1, 3'h2, 2'h0, 2'h0, 1'h0, 4},
      '{1'h1, 2'h2, 1'h0, 2'h0, 1'h0, 3'h1, 2'h1, 2'h1, 1'h0, 8}
   };

   logic clk = 1'h0;
   logic reset = 1'h1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   cwh_pkg::cwh_cpu_req_t cpu_req;
   cwh_pkg::cwh_cpu_rsp_t cpu_rsp;
   logic [1:0] cpu_clk_src;
   logic [3:0] irq_req;
   logic [7:0] pin_in = 8'h00;
   logic [7:0] pin_out;
   logic [1:0] osc_run;
   logic periph_clk_en;
   logic cmd_wait = 1'h0;
   logic cmd_halt = 1'h0;
   logic cmd_ie = 1'h0;
   logic [3:0] cmd_irq = 4'h0;
   int mismatches = 0;
   int checks_done = 0;

   always #4 clk = ~clk;

   cwh_standby_ctrl #(.PIN_W(8), .IRQ_W(4)) uut (
      .clk(clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .cpu_clk_src(cpu_clk_src),
      .irq_req(irq_req), .pin_in(pin_in), .pin_out(pin_out),
      .osc_run(osc_run), .periph_clk_en(periph_clk_en)
   );

   cwh_cpu_model #(.IRQ_W(4)) core (
      .clk(clk), .reset(reset), .cmd_wait(cmd_wait), .cmd_halt(cmd_halt),
      .cmd_ie(cmd_ie), .cmd_irq(cmd_irq), .cpu_rsp(cpu_rsp),
      .cpu_req(cpu_req), .irq_req(irq_req)
   );

   // ==========
   // Tasks
   task automatic stop_test();
      if (mismatches == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'h0 && n < 20);
      q = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      if (n >= 20)
      begin
         mismatches++;
         stop_test();
      end
   endtask : bus

   task automatic enter(input logic halt);
      @(posedge clk);
      cmd_wait <= !halt;
      cmd_halt <= halt;
      @(posedge clk);
      cmd_wait <= 1'h0;
      cmd_halt <= 1'h0;
   endtask : enter

   task automatic count(input int n, output int p);
      p = 0;
      repeat (n)
      begin
         @(posedge clk);
         if (cpu_rsp.clk_en !== 1'h0)
            p++;
      end
   endtask : count

   task automatic wait_stop();
      int n;
      n = 0;
      do @(posedge clk); while (cpu_rsp.stopped !== 1'h1 && ++n < 10);
   endtask : wait_stop

   // ==========
   // Watchdog, well beyond the expected few hundred cycles
   initial
   begin
      #200000;
      mismatches++;
      stop_test();
   end

   // ==========
   // Main sequence
   initial
   begin
      logic [31:0] q;
      logic [7:0] pat;
      logic [7:0] alt;
      int p;
      int n;
      repeat (8) @(posedge clk);
      reset <= 1'h0;
      for (int a = 0; a < 4; a++)
      begin
         bus(1'h0, 4'(a * 4), 32'h0000_0000, q);
         check(q, (a == 3) ? 32'h0000_0001 : 32'h0000_0000);
      end
      check({osc_run, periph_clk_en, pin_out}, 11'h700);
      foreach (rows[i])
      begin
         pat = 8'h3C ^ 8'(i * 37);
         alt = ~pat;
         bus(1'h1, 4'h8, {31'h0, rows[i].halt_v}, q);
         bus(1'h1, 4'h4, {26'h0, rows[i].src, 1'h0, rows[i].code}, q);
         bus(1'h1, 4'h0, {24'h0, rows[i].wsel, rows[i].byp, 5'h00}, q);
         cmd_ie <= rows[i].ie;
         pin_in <= pat;
         repeat (3) @(posedge clk);
         if (rows[i].how == 2'h1)
            bus(1'h1, 4'h0, {24'h0, rows[i].wsel, rows[i].byp, 5'h01}, q);
         else
            enter(rows[i].how == 2'h2);
         wait_stop();
         check(cpu_rsp.stopped, 1'h1);
         pin_in <= alt;
         count(6, p);
         check(32'(p), 32'h0000_0000);
         check(pin_out, pat);
         check({osc_run, periph_clk_en}, 3'h7);
         cmd_irq <= 4'(1 << (i % 4));
         @(posedge clk);
         cmd_irq <= 4'h0;
         n = 0;
         do @(posedge clk); while (cpu_rsp.resume !== 1'h1 && ++n < 10);
         check(cpu_rsp.resume, 1'h1);
         check(cpu_rsp.take_vector, rows[i].ie);
         repeat (4) @(posedge clk);
         count(16, p);
         check(32'(p), 32'(rows[i].x_pul));
         check(cpu_clk_src, rows[i].x_src);
         check(pin_out, alt);
         bus(1'h0, 4'hC, 32'h0000_0000, q);
         check(q, {25'h0, rows[i].halt_v, rows[i].x_und, rows[i].x_src,
            3'h1});
      end
      // Entry by the other variant's method is refused
      bus(1'h1, 4'h8, 32'h0000_0000, q);
      enter(1'h1);
      count(4, p);
      check(cpu_rsp.stopped, 1'h0);
      bus(1'h1, 4'h8, 32'h0000_0001, q);
      bus(1'h1, 4'h0, 32'h0000_0001, q);
      enter(1'h0);
      count(4, p);
      check(cpu_rsp.stopped, 1'h0);
      // Reset ends a wait with no request pending
      bus(1'h1, 4'h8, 32'h0000_0000, q);
      cmd_ie <= 1'h0;
      enter(1'h0);
      wait_stop();
      bus(1'h0, 4'h0, 32'h0000_0000, q);
      check(q, 32'h0000_0001);
      reset <= 1'h1;
      repeat (2) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      check(cpu_rsp.stopped, 1'h0);
      bus(1'h0, 4'hC, 32'h0000_0000, q);
      check(q, 32'h0000_0001);
      stop_test();
   end
endmodule : cwh_standby_ctrl_tb
